// ==== hw/spdc_ctrl.sv ====
// controller end: software orders in, power-down pin sequencing out
// Function
// - memory enters power-down on cke low with nop
// - no cke low during mode set, calibration, access
// - cke may drop during activate, precharge, refresh
// - one clock from activate/precharge/refresh to entry
// - write to entry: latency+4+recovery, chop4 two less
// - write-autoprecharge to entry: latency+4+recovery+1, chop4 less
// - write recovery taken from mode register bits
// - mode-set update delay before entry
// - termination asynchronous around slow-exit power-down
// - entry gates all buffers except few inputs
// - only nops until entry hold time passes
// - unlocked loop at entry needs reset after exit
// - open bank gives active, else precharge power-down
// - fast exit keeps loop on, slow turns off
// - during power-down hold cke low, reset high
// - reset low pulls memory out of power-down
// - respect minimum residency, leave before nine intervals
// - exit on cke high, then hold cke high
// - slow exit: locked-loop delay before read, termination
// - basic exit delay before refresh after exit
// - locked-loop exit delay before next entry
// - cke raised during refresh stays high through it
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module spdc_ctrl #(
    parameter int READ_LATENCY = 5,
    parameter int WRITE_LATENCY = 5,
    parameter int XP_CYC = 3,
    parameter int CKE_CYC = 3,
    parameter int PD_MIN_CYC = 3,
    parameter int MOD_CYC = 12,
    parameter int ZQ_CYC = 64,
    parameter int RFC_CYC = 7,
    parameter int DLLK_CYC = 512,
    parameter int REFI_CYC = 195,
    parameter int PD_MAX_CYC = spdc_pkg::PD_MAX_REFI * REFI_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    spdc_if.ctrl mem,
    input wire logic [spdc_pkg::REG_AW-1:0] reg_addr_in,
    input wire logic [spdc_pkg::REG_DW-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [spdc_pkg::REG_DW-1:0] reg_rdata_out
);
    localparam int CW = spdc_pkg::CNT_W;
    localparam int AW = spdc_pkg::ADDR_W;
    localparam int BW = spdc_pkg::BANK_W;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_PD = 2'h1,
        ST_EXIT = 2'h3
    } spdc_st_e;

    spdc_st_e state_ff;
    logic pend_ff;
    spdc_pkg::spdc_cmd_e pcmd_ff;
    logic [BW-1:0] pbank_ff;
    logic [AW-1:0] paddr_ff;
    logic pd_req_ff;
    logic term_req_ff;
    logic mrst_req_ff;
    logic [AW-1:0] mode0_ff;
    logic [CW-1:0] entry_cnt_ff;
    logic [CW-1:0] xp_cnt_ff;
    logic [CW-1:0] xpdll_cnt_ff;
    logic [CW-1:0] rfc_cnt_ff;
    logic [CW-1:0] cke_cnt_ff;
    logic [CW-1:0] res_cnt_ff;
    logic [CW-1:0] dllk_cnt_ff;
    logic dll_locked_ff;
    logic dll_rst_need_ff;
    logic forced_ff;
    logic cke_ff;
    logic term_ff;
    spdc_pkg::spdc_cmd_e cmd_ff;
    logic [BW-1:0] bank_ff;
    logic [AW-1:0] addr_ff;
    logic [spdc_pkg::REG_DW-1:0] rdata_ff;
    logic [CW-1:0] gap;
    logic is_read;
    logic slow_wait;
    logic issue;
    logic enter;
    logic leave;
    logic pd_max_hit;
    logic dll_reset_set;

    // ------------------------------------------------------------
    // decisions
    // ------------------------------------------------------------
    assign is_read = pcmd_ff == spdc_pkg::CMD_RD;
    // active power-down exit is treated like slow exit: costs a few clocks, never unsafe
    assign slow_wait = !mode0_ff[spdc_pkg::MODE0_FAST_EXIT_BIT] && xpdll_cnt_ff != '0;
    assign issue = pend_ff && state_ff == ST_RUN && !mrst_req_ff && xp_cnt_ff == '0
        && !(is_read && slow_wait)
        && !(is_read && dll_rst_need_ff);
    assign enter = state_ff == ST_RUN && pd_req_ff && !pend_ff && !mrst_req_ff
        && entry_cnt_ff == '0
        && xpdll_cnt_ff == '0
        && xp_cnt_ff == '0;
    assign pd_max_hit = res_cnt_ff >= CW'(PD_MAX_CYC);
    assign leave = state_ff == ST_PD
        && ((!pd_req_ff && res_cnt_ff >= CW'(PD_MIN_CYC)) || pd_max_hit);
    assign dll_reset_set = issue && pcmd_ff == spdc_pkg::CMD_MODE
        && pbank_ff == spdc_pkg::MR_SEL_MODE0 && paddr_ff[spdc_pkg::MODE0_DLL_RESET_BIT];

    // least spacing from the issued command to a cke-low edge
    always_comb
    begin
        gap = '0;
        case (pcmd_ff)
            spdc_pkg::CMD_ACT, spdc_pkg::CMD_PRE, spdc_pkg::CMD_REF:
                gap = CW'(spdc_pkg::CMD_TO_ENTRY_CK);
            spdc_pkg::CMD_RD:
                gap = CW'(READ_LATENCY + spdc_pkg::BURST_CK + spdc_pkg::EXTRA_CK);
            spdc_pkg::CMD_WR:
                gap = CW'(WRITE_LATENCY + spdc_pkg::BURST_CK
                    + spdc_pkg::wr_clocks(mode0_ff[spdc_pkg::MODE0_WR_MSB
                        :spdc_pkg::MODE0_WR_LSB])
                    + (paddr_ff[spdc_pkg::ADDR_AP_BIT] ? spdc_pkg::EXTRA_CK : 0)
                    - ((mode0_ff[spdc_pkg::MODE0_BL_MSB:spdc_pkg::MODE0_BL_LSB]
                        == spdc_pkg::BL_CHOP4_FIXED) ? spdc_pkg::CHOP4_SAVE_CK : 0));
            spdc_pkg::CMD_MODE: gap = CW'(MOD_CYC);
            spdc_pkg::CMD_ZQ: gap = CW'(ZQ_CYC);
            default: gap = '0;
        endcase
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pend_ff <= 1'b0;
            pcmd_ff <= spdc_pkg::CMD_NOP;
            pbank_ff <= '0;
            paddr_ff <= '0;
        end
        else if (reg_wr_in && reg_addr_in == spdc_pkg::REG_CMD && !pend_ff)
        begin
            pend_ff <= 1'b1;
            pcmd_ff <= spdc_pkg::spdc_cmd_e'(reg_wdata_in[spdc_pkg::CMD_OP_LSB +: 3]);
            pbank_ff <= reg_wdata_in[spdc_pkg::CMD_BANK_LSB +: BW];
            paddr_ff <= reg_wdata_in[spdc_pkg::CMD_ADDR_LSB +: AW];
        end
        else if (issue)
            pend_ff <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pd_req_ff <= 1'b0;
            term_req_ff <= 1'b0;
            mrst_req_ff <= 1'b1;
        end
        else if (reg_wr_in && reg_addr_in == spdc_pkg::REG_PD)
        begin
            pd_req_ff <= reg_wdata_in[spdc_pkg::PD_REQ_BIT];
            term_req_ff <= reg_wdata_in[spdc_pkg::PD_TERM_BIT];
            mrst_req_ff <= reg_wdata_in[spdc_pkg::PD_MRST_BIT];
        end
    end

    // forced exit flag: a new hit beats the write-one clear
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            forced_ff <= 1'b0;
        else if (leave && pd_max_hit)
            forced_ff <= 1'b1;
        else if (reg_wr_in && reg_addr_in == spdc_pkg::REG_STATUS
            && reg_wdata_in[spdc_pkg::ST_FORCED_BIT])
            forced_ff <= 1'b0;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_ff <= '0;
        else if (reg_rd_in)
        begin
            rdata_ff <= '0;
            case (reg_addr_in)
                spdc_pkg::REG_CMD:
                begin
                    rdata_ff[spdc_pkg::CMD_OP_LSB +: 3] <= pcmd_ff;
                    rdata_ff[spdc_pkg::CMD_BANK_LSB +: BW] <= pbank_ff;
                    rdata_ff[spdc_pkg::CMD_ADDR_LSB +: AW] <= paddr_ff;
                end
                spdc_pkg::REG_PD:
                begin
                    rdata_ff[spdc_pkg::PD_REQ_BIT] <= pd_req_ff;
                    rdata_ff[spdc_pkg::PD_TERM_BIT] <= term_req_ff;
                    rdata_ff[spdc_pkg::PD_MRST_BIT] <= mrst_req_ff;
                end
                spdc_pkg::REG_STATUS:
                begin
                    rdata_ff[spdc_pkg::ST_STATE_LSB +: 2] <= state_ff;
                    rdata_ff[spdc_pkg::ST_PEND_BIT] <= pend_ff;
                    rdata_ff[spdc_pkg::ST_LOCKED_BIT] <= dll_locked_ff;
                    rdata_ff[spdc_pkg::ST_DLLRST_BIT] <= dll_rst_need_ff;
                    rdata_ff[spdc_pkg::ST_FORCED_BIT] <= forced_ff;
                end
                default: rdata_ff <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power-down sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_ff <= ST_RUN;
        else if (mrst_req_ff)
            state_ff <= ST_RUN;
        else
        begin
            case (state_ff)
                ST_RUN: if (enter) state_ff <= ST_PD;
                ST_PD: if (leave) state_ff <= ST_EXIT;
                ST_EXIT:
                    if (cke_cnt_ff == '0 && rfc_cnt_ff == '0)
                        state_ff <= ST_RUN;
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            entry_cnt_ff <= '0;
            rfc_cnt_ff <= '0;
            res_cnt_ff <= '0;
            cke_cnt_ff <= '0;
            xp_cnt_ff <= '0;
            xpdll_cnt_ff <= '0;
        end
        else
        begin
            if (issue && gap > entry_cnt_ff)
                entry_cnt_ff <= gap;
            else if (entry_cnt_ff != '0)
                entry_cnt_ff <= entry_cnt_ff - 1'b1;
            if (issue && pcmd_ff == spdc_pkg::CMD_REF)
                rfc_cnt_ff <= CW'(RFC_CYC);
            else if (rfc_cnt_ff != '0)
                rfc_cnt_ff <= rfc_cnt_ff - 1'b1;
            res_cnt_ff <= (state_ff == ST_PD) ? res_cnt_ff + 1'b1 : '0;
            if (leave)
            begin
                cke_cnt_ff <= CW'(CKE_CYC);
                xp_cnt_ff <= CW'(XP_CYC);
                xpdll_cnt_ff <= CW'(spdc_pkg::XPDLL_CYC);
            end
            else
            begin
                if (cke_cnt_ff != '0)
                    cke_cnt_ff <= cke_cnt_ff - 1'b1;
                if (xp_cnt_ff != '0)
                    xp_cnt_ff <= xp_cnt_ff - 1'b1;
                if (xpdll_cnt_ff != '0)
                    xpdll_cnt_ff <= xpdll_cnt_ff - 1'b1;
            end
        end
    end

    // loop lock follows a loop reset; entry while unlocked owes a new one
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dllk_cnt_ff <= '0;
            dll_locked_ff <= 1'b0;
            dll_rst_need_ff <= 1'b0;
        end
        else if (mrst_req_ff)
        begin
            dllk_cnt_ff <= '0;
            dll_locked_ff <= 1'b0;
            dll_rst_need_ff <= 1'b0;
        end
        else
        begin
            if (dll_reset_set)
            begin
                dllk_cnt_ff <= CW'(DLLK_CYC);
                dll_locked_ff <= 1'b0;
            end
            else if (dllk_cnt_ff != '0)
            begin
                dllk_cnt_ff <= dllk_cnt_ff - 1'b1;
                dll_locked_ff <= dllk_cnt_ff == CW'(1);
            end
            if (enter && !dll_locked_ff)
                dll_rst_need_ff <= 1'b1;
            else if (dll_reset_set)
                dll_rst_need_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            mode0_ff <= '0;
        else if (issue && pcmd_ff == spdc_pkg::CMD_MODE && pbank_ff == spdc_pkg::MR_SEL_MODE0)
            mode0_ff <= paddr_ff;
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cke_ff <= 1'b0;
            term_ff <= 1'b0;
            cmd_ff <= spdc_pkg::CMD_NOP;
            bank_ff <= '0;
            addr_ff <= '0;
        end
        else
        begin
            // cke low while memory reset is held, so it is low at release
            cke_ff <= !mrst_req_ff && !(enter || (state_ff == ST_PD && !leave));
            term_ff <= term_req_ff && !slow_wait && !dll_rst_need_ff;
            cmd_ff <= issue ? pcmd_ff : spdc_pkg::CMD_NOP;
            bank_ff <= issue ? pbank_ff : bank_ff;
            addr_ff <= issue ? paddr_ff : addr_ff;
        end
    end

    assign mem.cke = cke_ff;
    assign mem.termination_control = term_ff;
    assign mem.mem_reset_n = !mrst_req_ff;
    assign mem.cmd = cmd_ff;
    assign mem.bank = bank_ff;
    assign mem.addr = addr_ff;
    assign reg_rdata_out = rdata_ff;
endmodule

// ==== hw/spdc_dram.sv ====
// sdram end: power-down entry, exit, buffer gating and locked-loop state
`timescale 1ns/1ps
module spdc_dram #(
    parameter int CPDED_CYC = 2,
    parameter int ANPD_CYC = 4
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    spdc_if.dram mem,
    output spdc_pkg::spdc_pd_e pd_state_out,
    output logic dll_on_out,
    output logic buffers_on_out,
    output logic term_async_out,
    output logic [spdc_pkg::NUM_BANKS-1:0] banks_open_out,
    output logic [spdc_pkg::ADDR_W-1:0] mode0_out,
    output logic in_reset_out
);
    localparam int CW = spdc_pkg::CNT_W;
    localparam int TERM_TAIL = ANPD_CYC + spdc_pkg::XPDLL_CYC;

    spdc_pkg::spdc_pd_e pd_ff;
    logic cke_prev_ff;
    logic [spdc_pkg::NUM_BANKS-1:0] banks_ff;
    logic [spdc_pkg::ADDR_W-1:0] mode0_ff;
    logic dll_ff;
    logic buf_ff;
    logic term_async_ff;
    logic rst_ff;
    logic [CW-1:0] cpd_cnt_ff;
    logic [CW-1:0] term_cnt_ff;
    logic is_nop;
    logic entry;
    logic exit_pd;
    logic run;

    assign is_nop = mem.cmd == spdc_pkg::CMD_NOP;
    assign entry = pd_ff == spdc_pkg::PD_NONE && cke_prev_ff && !mem.cke && is_nop;
    assign exit_pd = pd_ff != spdc_pkg::PD_NONE && mem.cke && is_nop;
    // commands act only while awake; state is frozen across power-down
    assign run = pd_ff == spdc_pkg::PD_NONE && mem.cke && mem.mem_reset_n;

    // ------------------------------------------------------------
    // power-down state
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pd_ff <= spdc_pkg::PD_NONE;
            cke_prev_ff <= 1'b0;
            rst_ff <= 1'b1;
        end
        else
        begin
            cke_prev_ff <= mem.cke;
            rst_ff <= !mem.mem_reset_n;
            if (!mem.mem_reset_n)
                pd_ff <= spdc_pkg::PD_NONE;
            else if (entry)
                pd_ff <= (banks_ff != '0) ? spdc_pkg::PD_ACTIVE : spdc_pkg::PD_PRECH;
            else if (exit_pd)
                pd_ff <= spdc_pkg::PD_NONE;
        end
    end

    // ------------------------------------------------------------
    // bank and mode register tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            banks_ff <= '0;
            mode0_ff <= '0;
        end
        else if (!mem.mem_reset_n)
        begin
            banks_ff <= '0;
            mode0_ff <= '0;
        end
        else if (run)
        begin
            case (mem.cmd)
                spdc_pkg::CMD_ACT: banks_ff[mem.bank] <= 1'b1;
                spdc_pkg::CMD_PRE:
                    if (mem.addr[spdc_pkg::ADDR_AP_BIT])
                        banks_ff <= '0;
                    else
                        banks_ff[mem.bank] <= 1'b0;
                spdc_pkg::CMD_RD, spdc_pkg::CMD_WR:
                    if (mem.addr[spdc_pkg::ADDR_AP_BIT])
                        banks_ff[mem.bank] <= 1'b0;
                spdc_pkg::CMD_MODE:
                    if (mem.bank == spdc_pkg::MR_SEL_MODE0)
                        mode0_ff <= mem.addr;
                default: banks_ff <= banks_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // locked loop and buffer gating
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            dll_ff <= 1'b1;
        else
            dll_ff <= !(pd_ff == spdc_pkg::PD_PRECH
                && !mode0_ff[spdc_pkg::MODE0_FAST_EXIT_BIT]);
    end

    // clock, cke, termination and reset receivers stay on; only the rest is gated
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            buf_ff <= 1'b1;
            cpd_cnt_ff <= '0;
        end
        else if (entry)
            cpd_cnt_ff <= CW'(CPDED_CYC);
        else if (pd_ff == spdc_pkg::PD_NONE)
            buf_ff <= 1'b1;
        else if (cpd_cnt_ff != '0)
            cpd_cnt_ff <= cpd_cnt_ff - 1'b1;
        else
            buf_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // asynchronous termination window
    // ------------------------------------------------------------
    // the lead before cke falls cannot be seen here; async starts at entry
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            term_async_ff <= 1'b0;
            term_cnt_ff <= '0;
        end
        else if (pd_ff == spdc_pkg::PD_PRECH && !mode0_ff[spdc_pkg::MODE0_FAST_EXIT_BIT])
        begin
            term_async_ff <= 1'b1;
            term_cnt_ff <= CW'(TERM_TAIL);
        end
        else if (term_cnt_ff != '0)
            term_cnt_ff <= term_cnt_ff - 1'b1;
        else
            term_async_ff <= 1'b0;
    end

    assign pd_state_out = pd_ff;
    assign dll_on_out = dll_ff;
    assign buffers_on_out = buf_ff;
    assign term_async_out = term_async_ff;
    assign banks_open_out = banks_ff;
    assign mode0_out = mode0_ff;
    assign in_reset_out = rst_ff;
endmodule

// ==== hw/spdc_if.sv ====
// pin bundle between memory controller and sdram power-down logic
`timescale 1ns/1ps
interface spdc_if;
    logic cke;
    logic mem_reset_n;
    logic termination_control;
    spdc_pkg::spdc_cmd_e cmd;
    logic [spdc_pkg::BANK_W-1:0] bank;
    logic [spdc_pkg::ADDR_W-1:0] addr;

    modport ctrl (
        output cke,
        output mem_reset_n,
        output termination_control,
        output cmd,
        output bank,
        output addr
    );
    modport dram (
        input cke,
        input mem_reset_n,
        input termination_control,
        input cmd,
        input bank,
        input addr
    );
endinterface

// ==== hw/spdc_pkg.sv ====
// shared constants and types for the sdram power-down link
package spdc_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 3;
    localparam int NUM_BANKS = 8;
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam int CNT_W = 16;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_MODE = 3'h1,
        CMD_REF = 3'h2,
        CMD_PRE = 3'h3,
        CMD_ACT = 3'h4,
        CMD_WR = 3'h5,
        CMD_RD = 3'h6,
        CMD_ZQ = 3'h7
    } spdc_cmd_e;

    typedef enum logic [1:0] {
        PD_NONE = 2'h0,
        PD_ACTIVE = 2'h1,
        PD_PRECH = 2'h3
    } spdc_pd_e;

    // ------------------------------------------------------------
    // mode register zero layout and address bits
    // ------------------------------------------------------------
    localparam logic [BANK_W-1:0] MR_SEL_MODE0 = 3'h0;
    localparam int MODE0_WR_LSB = 9;
    localparam int MODE0_WR_MSB = 11;
    localparam int MODE0_FAST_EXIT_BIT = 12;
    localparam int MODE0_DLL_RESET_BIT = 8;
    localparam int MODE0_BL_LSB = 0;
    localparam int MODE0_BL_MSB = 1;
    localparam logic [1:0] BL_CHOP4_FIXED = 2'h2;
    localparam int ADDR_AP_BIT = 10;

    // ------------------------------------------------------------
    // timing figures
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int CMD_TO_ENTRY_CK = 1;
    localparam int BURST_CK = 4;
    localparam int EXTRA_CK = 1;
    localparam int CHOP4_SAVE_CK = 2;
    localparam int XPDLL_MIN_CK = 10;
    localparam int XPDLL_MIN_NS = 24;
    localparam int XPDLL_NS_CYC = (XPDLL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XPDLL_CYC = (XPDLL_MIN_CK > XPDLL_NS_CYC) ? XPDLL_MIN_CK : XPDLL_NS_CYC;
    localparam int PD_MAX_REFI = 9;

    // ------------------------------------------------------------
    // controller register map
    // ------------------------------------------------------------
    localparam logic [REG_AW-1:0] REG_CMD = 4'h0;
    localparam logic [REG_AW-1:0] REG_PD = 4'h4;
    localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BANK_LSB = 3;
    localparam int CMD_ADDR_LSB = 6;
    localparam int PD_REQ_BIT = 0;
    localparam int PD_TERM_BIT = 1;
    localparam int PD_MRST_BIT = 2;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_PEND_BIT = 2;
    localparam int ST_LOCKED_BIT = 3;
    localparam int ST_DLLRST_BIT = 4;
    localparam int ST_FORCED_BIT = 5;

    // write recovery clocks from the mode register field
    function automatic int wr_clocks(input logic [2:0] code);
        case (code)
            3'h1: wr_clocks = 5;
            3'h2: wr_clocks = 6;
            3'h3: wr_clocks = 7;
            3'h4: wr_clocks = 8;
            3'h5: wr_clocks = 10;
            3'h6: wr_clocks = 12;
            3'h7: wr_clocks = 14;
            default: wr_clocks = 16;
        endcase
    endfunction
endpackage

// ==== tb/spdc_assertions.sv ====
// pin-level checks between the controller end and the sdram end
`timescale 1ns/1ps
module spdc_assertions (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cke,
    input wire logic mem_reset_n,
    input wire logic termination_control,
    input spdc_pkg::spdc_cmd_e cmd,
    input wire logic [spdc_pkg::BANK_W-1:0] bank,
    input wire logic [spdc_pkg::ADDR_W-1:0] addr
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // eleven clocks high: one short of the twelve-clock shortest write spacing and mode-set delay
    sequence hi_11;
        cke [*8] ##1 cke [*3];
    endsequence
    sequence exit_nops;
        (cmd == spdc_pkg::CMD_NOP) [*3];
    endsequence
    a_nop_when_low: assert property (
        !cke |-> cmd == spdc_pkg::CMD_NOP) else $error("command while cke low");
    a_min_residency: assert property (
        $fell(cke) |-> !cke [*3]) else $error("power-down too short");
    a_cmd_entry_gap: assert property (
        cmd inside {spdc_pkg::CMD_ACT, spdc_pkg::CMD_PRE, spdc_pkg::CMD_REF} |=> cke)
        else $error("entry too soon after command");
    a_read_entry_gap: assert property (
        cmd == spdc_pkg::CMD_RD |=> cke [*8] ##1 cke) else $error("entry too soon after read");
    a_write_entry_gap: assert property (
        cmd == spdc_pkg::CMD_WR |=> hi_11) else $error("entry too soon after write");
    a_mode_entry_gap: assert property (
        cmd == spdc_pkg::CMD_MODE |=> hi_11) else $error("entry too soon after mode set");
    a_exit_cmd_gap: assert property (
        $rose(cke) |-> exit_nops) else $error("command too soon after exit");
    a_reentry_gap: assert property (
        $rose(cke) |-> cke [*8] ##1 cke [*2]) else $error("re-entry too soon after exit");
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the power-down link with both ends joined
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    spdc_pkg::spdc_pd_e pd_state_out;
    logic dll_on_out, buffers_on_out, term_async_out, in_reset_out;
    logic [7:0] banks_open_out;
    logic [12:0] mode0_out;
    logic [31:0] s;
    int n_fail = 0;
    int n_checks = 0;
    spdc_if mem ();
    spdc_ctrl #(.DLLK_CYC(16), .REFI_CYC(20)) spdc_ctrl_i (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .mem(mem.ctrl), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out));
    spdc_dram spdc_dram_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .mem(mem.dram),
        .pd_state_out(pd_state_out), .dll_on_out(dll_on_out), .buffers_on_out(buffers_on_out),
        .term_async_out(term_async_out), .banks_open_out(banks_open_out), .mode0_out(mode0_out),
        .in_reset_out(in_reset_out));
    spdc_assertions spdc_assertions_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .cke(mem.cke), .mem_reset_n(mem.mem_reset_n), .cmd(mem.cmd), .bank(mem.bank),
        .termination_control(mem.termination_control), .addr(mem.addr));
    initial forever #20 clk_in = ~clk_in;
    task automatic results();
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    // pending is polled, not timed: issue waits out power-down and exit spacing
    task automatic issue(input logic [2:0] op, input logic [2:0] b, input logic [12:0] a);
        wr(spdc_pkg::REG_CMD, {13'h0, a, b, op});
        for (int i = 0; i < 200; i++)
        begin
            rd(spdc_pkg::REG_STATUS, s);
            if (s[2] === 1'b0) break;
        end
        `CHK(s[2], 1'b0)
        if (s[2] !== 1'b0) results();
        repeat (3) @(posedge clk_in);
    endtask
    task automatic wait_pd(input spdc_pkg::spdc_pd_e e);
        for (int i = 0; i < 300 && pd_state_out !== e; i++) @(posedge clk_in);
        `CHK(pd_state_out, e)
        if (pd_state_out !== e) results();
        repeat (4) @(posedge clk_in);
    endtask
    task automatic pd_cycle(input spdc_pkg::spdc_pd_e e, input logic dll);
        wr(spdc_pkg::REG_PD, 32'h1);
        wait_pd(e);
        `CHK(dll_on_out, dll)
        `CHK(buffers_on_out, 1'b0)
        `CHK(term_async_out, !dll)
        wr(spdc_pkg::REG_PD, 32'h0);
        wait_pd(spdc_pkg::PD_NONE);
        `CHK(buffers_on_out, 1'b1)
        repeat (8) @(posedge clk_in);
    endtask
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1 `CHK(in_reset_out, 1'b1)
        wr(spdc_pkg::REG_PD, 32'h0);
        repeat (12) @(posedge clk_in);
        `CHK(in_reset_out, 1'b0)
        issue(spdc_pkg::CMD_MODE, 3'h0, 13'h0300);
        `CHK(mode0_out, 13'h0300)
        repeat (30) @(posedge clk_in);
        pd_cycle(spdc_pkg::PD_PRECH, 1'b0);
        issue(spdc_pkg::CMD_MODE, 3'h0, 13'h1200);
        pd_cycle(spdc_pkg::PD_PRECH, 1'b1);
        issue(spdc_pkg::CMD_ACT, 3'h1, 13'h0010);
        issue(spdc_pkg::CMD_WR, 3'h1, 13'h0000);
        issue(spdc_pkg::CMD_RD, 3'h1, 13'h0000);
        pd_cycle(spdc_pkg::PD_ACTIVE, 1'b1);
        `CHK(banks_open_out, 8'h02)
        `CHK(mode0_out, 13'h1200)
        rd(spdc_pkg::REG_CMD, s);
        `CHK(s, 32'h0000000e)
        rd(4'hc, s);
        `CHK(s, 32'h0)
        issue(spdc_pkg::CMD_REF, 3'h0, 13'h0000);
        wr(spdc_pkg::REG_PD, 32'h3);
        wait_pd(spdc_pkg::PD_ACTIVE);
        repeat (200) @(posedge clk_in);
        rd(spdc_pkg::REG_STATUS, s);
        `CHK(s[5:3], 3'h5)
        `CHK(mem.termination_control, 1'b1)
        wr(spdc_pkg::REG_PD, 32'h5);
        wait_pd(spdc_pkg::PD_NONE);
        `CHK(in_reset_out, 1'b1)
        results();
    end
endmodule
